// ===== sdr_pkg.sv
package sdr_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] SDR_OFS_CTRL = 8'h00; // write-only commands
  localparam logic [7:0] SDR_OFS_MODE = 8'h04; // mode bits and fixed select
  localparam logic [7:0] SDR_OFS_RX = 8'h08; // rx_data_reg
  localparam logic [7:0] SDR_OFS_TX = 8'h0c; // tx_data_reg
  localparam logic [7:0] SDR_OFS_STATUS = 8'h10; // status_reg
  localparam logic [7:0] SDR_OFS_IER = 8'h14; // irq_enable_reg
  localparam logic [7:0] SDR_OFS_IDR = 8'h18; // irq_disable_reg
  localparam logic [7:0] SDR_OFS_IMR = 8'h1c; // irq_mask_reg

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SDR_CTRL_EN_BIT = 0; // enable command
  localparam int SDR_CTRL_DIS_BIT = 1; // disable command, wins over enable
  localparam int SDR_CTRL_SWRST_BIT = 7; // software reset of the slice
  localparam int SDR_MODE_MASTER_BIT = 0; // master_mode
  localparam int SDR_MODE_VARSEL_BIT = 1; // variable_select_mode
  localparam int SDR_MODE_DECODE_BIT = 2; // select_decode_mode
  localparam int SDR_SEL_LSB = 16; // periph_chip_select field low bit
  localparam int SDR_SEL_MSB = 19; // periph_chip_select field high bit
  localparam int SDR_WORD_MSB = 15; // tx_word / rx word high bit
  localparam int SDR_ENABLED_BIT = 16; // enabled_status in status_reg
  localparam int SDR_FLAGS_W = 6; // flag bits 5..0

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] SDR_RX_RESET = 32'h0000_0000; // rx_data_reg
  localparam logic [31:0] SDR_MODE_RESET = 32'h0000_0000; // mode register
  localparam logic [31:0] SDR_TX_RESET = 32'h0000_0000; // tx_data_reg
  localparam logic [5:0] SDR_MASK_RESET = 6'h00; // irq mask
  localparam logic [3:0] SDR_CS_IDLE = 4'hf; // all select lines inactive

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tx_dma_done; // bit 5
    logic rx_dma_done; // bit 4
    logic overrun; // bit 3
    logic mode_fault; // bit 2
    logic tx_empty; // bit 1
    logic rx_full; // bit 0
  } sdr_flags_t;

  typedef struct packed {
    logic [3:0] sel; // periph_chip_select written with the word
    logic [15:0] word; // tx_word
  } sdr_txword_t;

  typedef enum logic {SDR_BUS_IDLE, SDR_BUS_ACK} sdr_bus_state_t;

endpackage : sdr_pkg

// ===== sdr_sync3.sv
`timescale 1ns/1ps
module sdr_sync3
  import sdr_pkg::*;
(
  input logic clk, // block clock
  input logic rst_n, // synchronised reset, active low
  input logic async_in, // pin from outside the clock domain
  output logic level_q // filtered level, changes once stages 1 and 2 agree
);

  // ----------------------------------------------------------------
  // three-stage sampler
  // ----------------------------------------------------------------
  logic [2:0] stage_q; // stage 0 is read only by stage 1
  logic [2:0] stage_d; // next sampler value
  logic level_d; // next filtered level

  // shift the pin in and accept a change only when stages 1 and 2 agree
  always_comb
  begin
    stage_d = {stage_q[1:0], async_in};
    level_d = (stage_q[2] == stage_q[1]) ? stage_q[2] : level_q;
  end

  // reset to the idle (high) level so no false edge comes out of reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage_q <= 3'h7;
      level_q <= 1'b1;
    end
    else
    begin
      stage_q <= stage_d;
      level_q <= level_d;
    end
  end

endmodule : sdr_sync3

// ===== sdr_cs_decode.sv
`timescale 1ns/1ps
module sdr_cs_decode
  import sdr_pkg::*;
(
  input logic clk, // block clock
  input logic rst_n, // synchronised reset, active low
  input logic clear, // software reset, returns lines to idle
  input logic load, // word moves into the serializer
  input logic master, // master_mode
  input logic variable, // variable_select_mode
  input logic decode, // select_decode_mode
  input logic [3:0] mode_sel, // fixed select field of the mode register
  input logic [3:0] tx_sel, // select field written with the word
  output logic [3:0] lines_q // chip_select_lines, active low
);

  // ----------------------------------------------------------------
  // select decoding
  // ----------------------------------------------------------------
  // lowest zero bit wins; all ones selects nothing, lines stay idle
  function automatic logic [3:0] one_of_four(input logic [3:0] sel);
    logic [3:0] res;
    res = SDR_CS_IDLE;
    if (!sel[0]) res = 4'he;
    else if (!sel[1]) res = 4'hd;
    else if (!sel[2]) res = 4'hb;
    else if (!sel[3]) res = 4'h7;
    return res;
  endfunction : one_of_four

  logic [3:0] field; // chosen select field
  logic [3:0] lines_d; // next line levels

  // choose the source field and, unless decode mode passes it out as is, decode it when a word is loaded
  always_comb
  begin
    field = (variable && master) ? tx_sel : mode_sel;
    lines_d = lines_q;
    if (clear || !master)
      lines_d = SDR_CS_IDLE; // a slave never drives selects
    else if (load)
      lines_d = decode ? field : one_of_four(field);
  end

  // hold lines between words
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lines_q <= SDR_CS_IDLE;
    else
      lines_q <= lines_d;
  end

endmodule : sdr_cs_decode

// ===== sdr_regs.sv
`timescale 1ns/1ps
module sdr_regs
  import sdr_pkg::*;
(
  input logic clk, // 100 MHz block clock
  input logic rstn, // asynchronous reset, active low
  input logic wb_cyc_i, // wishbone cycle
  input logic wb_stb_i, // wishbone strobe
  input logic wb_we_i, // wishbone write
  input logic [7:0] wb_adr_i, // wishbone byte address
  input logic [3:0] wb_sel_i, // wishbone byte enables
  input logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input logic ser_rx_load, // pulse: serializer delivers a word
  input logic [15:0] ser_rx_word, // received word
  input logic ser_tx_take, // pulse: serializer takes the pending word
  output sdr_txword_t tx_word, // pending word and its select field
  output logic tx_pending, // a word waits for the serializer
  output logic [3:0] chip_select_lines, // select outputs, active low
  input logic fault_in_n, // external slave-select pin, low = fault in master
  input logic rx_dma_end, // rx channel end of transfer (counter zero)
  input logic tx_dma_end, // tx channel end of transfer (counter zero)
  output logic rx_dma_req, // request an rx dma transfer
  output logic tx_dma_req, // request a tx dma transfer
  output logic master_mode, // mode bit for the serializer
  output logic variable_select_mode, // mode bit for the serializer
  output logic select_decode_mode, // mode bit for the serializer
  output logic spi_enabled, // interface enabled
  output logic irq // interrupt request, active high
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_pipe_q; // release synchroniser
  logic rst_n; // synchronised reset used everywhere below

  // assert at once, release after two edges
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rst_pipe_q <= 2'b00;
    else
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
  end

  assign rst_n = rst_pipe_q[1];

  // ----------------------------------------------------------------
  // bus helpers
  // ----------------------------------------------------------------
  // word address match, used by the read mux and every write strobe
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    return adr[7:2] == ofs[7:2];
  endfunction : hit

  // expand byte enables to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : lane_mask

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sdr_bus_state_t state_q, state_d; // bus handshake
  logic ack_q, ack_d; // registered acknowledge
  logic [31:0] rdata_q, rdata_d; // registered read data
  logic [31:0] rx_q, rx_d; // rx_data_reg
  sdr_txword_t tx_q, tx_d; // tx_data_reg contents
  logic [31:0] mode_q, mode_d; // mode register
  logic enabled_q, enabled_d; // enabled_status
  sdr_flags_t flags_q, flags_d; // sticky and live flags
  logic [5:0] mask_q, mask_d; // irq_mask_reg
  logic irq_q, irq_d; // interrupt output register
  logic pend_q, pend_d; // tx_pending register
  logic rxreq_q, rxreq_d; // rx dma request register
  logic txreq_q, txreq_d; // tx dma request register
  logic fault_lvl; // synchronised fault pin
  logic fault_prev_q; // previous fault level for edge detect

  // ----------------------------------------------------------------
  // access strobes
  // ----------------------------------------------------------------
  logic commit; // access completes at this edge
  logic [31:0] wmask; // byte-lane mask
  logic [31:0] wdata; // write data with lanes applied
  logic ctrl_wr, mode_wr, tx_wr, ier_wr, idr_wr; // write strobes
  logic rx_rd, sr_rd; // read strobes with side effects
  logic swrst; // software reset command
  logic en_cmd, dis_cmd; // enable / disable commands
  logic fault_evt; // mode fault seen this cycle
  logic take; // pending word really taken

  // side effects land on the edge where the master samples ack
  always_comb
  begin
    commit = wb_cyc_i && wb_stb_i && ack_q;
    wmask = lane_mask(wb_sel_i);
    wdata = wb_dat_i & wmask;
    ctrl_wr = commit && wb_we_i && hit(wb_adr_i, SDR_OFS_CTRL);
    mode_wr = commit && wb_we_i && hit(wb_adr_i, SDR_OFS_MODE);
    tx_wr = commit && wb_we_i && hit(wb_adr_i, SDR_OFS_TX) && (wb_sel_i != 4'h0);
    ier_wr = commit && wb_we_i && hit(wb_adr_i, SDR_OFS_IER);
    idr_wr = commit && wb_we_i && hit(wb_adr_i, SDR_OFS_IDR);
    rx_rd = commit && !wb_we_i && hit(wb_adr_i, SDR_OFS_RX);
    sr_rd = commit && !wb_we_i && hit(wb_adr_i, SDR_OFS_STATUS);
    swrst = ctrl_wr && wdata[SDR_CTRL_SWRST_BIT];
    dis_cmd = ctrl_wr && wdata[SDR_CTRL_DIS_BIT];
    en_cmd = ctrl_wr && wdata[SDR_CTRL_EN_BIT] && !dis_cmd;
    // a fault is the pin falling while we are an enabled master
    fault_evt = mode_q[SDR_MODE_MASTER_BIT] && enabled_q && fault_prev_q && !fault_lvl;
    take = ser_tx_take && !flags_q.tx_empty && enabled_q;
  end

  // ----------------------------------------------------------------
  // bus handshake and read mux
  // ----------------------------------------------------------------
  // one wait cycle lets read data settle in a register before ack
  always_comb
  begin
    state_d = state_q;
    ack_d = 1'b0;
    rdata_d = rdata_q;
    case (state_q)
      SDR_BUS_IDLE:
      begin
        if (wb_cyc_i && wb_stb_i)
        begin
          state_d = SDR_BUS_ACK;
          ack_d = 1'b1;
          rdata_d = 32'h0000_0000; // unmapped and write-only read zero
          if (!wb_we_i)
          begin
            if (hit(wb_adr_i, SDR_OFS_MODE))
              rdata_d = mode_q;
            else if (hit(wb_adr_i, SDR_OFS_RX))
              rdata_d = rx_q;
            else if (hit(wb_adr_i, SDR_OFS_STATUS))
              rdata_d = {15'h0000, enabled_q, 10'h000, flags_q};
            else if (hit(wb_adr_i, SDR_OFS_IMR))
              rdata_d = {26'h000_0000, mask_q};
          end
        end
      end
      SDR_BUS_ACK:
        state_d = SDR_BUS_IDLE; // ack drops the cycle after it was given
      default:
        state_d = SDR_BUS_IDLE;
    endcase
  end

  // register the handshake
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= SDR_BUS_IDLE;
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      state_q <= state_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // fault pin crossing
  // ----------------------------------------------------------------
  sdr_sync3 u_fault_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(fault_in_n),
    .level_q(fault_lvl)
  );

  // keep the last filtered level for falling-edge detection
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      fault_prev_q <= 1'b1;
    else
      fault_prev_q <= fault_lvl;
  end

  // ----------------------------------------------------------------
  // data, mode, flags and mask
  // ----------------------------------------------------------------
  // hardware sets of rx_full, overrun and mode_fault win over software clears in the same cycle
  always_comb
  begin
    rx_d = rx_q;
    tx_d = tx_q;
    mode_d = mode_q;
    enabled_d = enabled_q;
    flags_d = flags_q;
    mask_d = mask_q;
    if (swrst)
    begin
      rx_d = SDR_RX_RESET;
      tx_d = sdr_txword_t'(SDR_TX_RESET[19:0]);
      mode_d = SDR_MODE_RESET;
      enabled_d = 1'b0;
      flags_d = sdr_flags_t'(6'h00);
      mask_d = SDR_MASK_RESET;
    end
    else
    begin
      if (mode_wr)
        mode_d = (mode_q & ~wmask) | wdata;
      if (dis_cmd)
        enabled_d = 1'b0;
      else if (en_cmd)
        enabled_d = 1'b1;
      // word right-justified, select status only in master mode
      if (ser_rx_load)
      begin
        rx_d = 32'h0000_0000;
        rx_d[SDR_WORD_MSB:0] = ser_rx_word;
        if (mode_q[SDR_MODE_MASTER_BIT])
          rx_d[SDR_SEL_MSB:SDR_SEL_LSB] = chip_select_lines;
      end
      if (tx_wr)
      begin
        tx_d.word = (tx_q.word & ~wmask[SDR_WORD_MSB:0]) | wdata[SDR_WORD_MSB:0];
        tx_d.sel = (tx_q.sel & ~wmask[SDR_SEL_MSB:SDR_SEL_LSB]) | wdata[SDR_SEL_MSB:SDR_SEL_LSB];
      end
      if (ser_rx_load)
        flags_d.rx_full = 1'b1;
      else if (rx_rd)
        flags_d.rx_full = 1'b0;
      if (ser_rx_load && flags_q.rx_full)
        flags_d.overrun = 1'b1;
      else if (sr_rd)
        flags_d.overrun = 1'b0;
      if (fault_evt)
        flags_d.mode_fault = 1'b1;
      else if (sr_rd)
        flags_d.mode_fault = 1'b0;
      // a write makes the word pending even if a take lands together
      if (!enabled_d)
        flags_d.tx_empty = 1'b0;
      else if (tx_wr)
        flags_d.tx_empty = 1'b0;
      else if (take || en_cmd)
        flags_d.tx_empty = 1'b1;
      mask_d = (mask_q | wdata[5:0] & {6{ier_wr}}) & ~(wdata[5:0] & {6{idr_wr}});
    end
    flags_d.rx_dma_done = rx_dma_end;
    flags_d.tx_dma_done = tx_dma_end;
  end

  // register data, mode, flags and mask
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_q <= SDR_RX_RESET;
      tx_q <= sdr_txword_t'(SDR_TX_RESET[19:0]);
      mode_q <= SDR_MODE_RESET;
      enabled_q <= 1'b0;
      flags_q <= sdr_flags_t'(6'h00);
      mask_q <= SDR_MASK_RESET;
    end
    else
    begin
      rx_q <= rx_d;
      tx_q <= tx_d;
      mode_q <= mode_d;
      enabled_q <= enabled_d;
      flags_q <= flags_d;
      mask_q <= mask_d;
    end
  end

  // ----------------------------------------------------------------
  // registered side outputs
  // ----------------------------------------------------------------
  // dma stops while its channel reports end of transfer
  always_comb
  begin
    irq_d = |(flags_d & mask_d);
    pend_d = enabled_d && !flags_d.tx_empty;
    rxreq_d = flags_d.rx_full && !rx_dma_end;
    txreq_d = flags_d.tx_empty && !tx_dma_end;
  end

  // register irq, pending and dma requests
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_q <= 1'b0;
      pend_q <= 1'b0;
      rxreq_q <= 1'b0;
      txreq_q <= 1'b0;
    end
    else
    begin
      irq_q <= irq_d;
      pend_q <= pend_d;
      rxreq_q <= rxreq_d;
      txreq_q <= txreq_d;
    end
  end

  // ----------------------------------------------------------------
  // chip select generation
  // ----------------------------------------------------------------
  sdr_cs_decode u_cs (
    .clk(clk),
    .rst_n(rst_n),
    .clear(swrst),
    .load(take),
    .master(mode_q[SDR_MODE_MASTER_BIT]),
    .variable(mode_q[SDR_MODE_VARSEL_BIT]),
    .decode(mode_q[SDR_MODE_DECODE_BIT]),
    .mode_sel(mode_q[SDR_SEL_MSB:SDR_SEL_LSB]),
    .tx_sel(tx_q.sel),
    .lines_q(chip_select_lines)
  );

  // ----------------------------------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign wb_dat_o = rdata_q;
  assign wb_ack_o = ack_q;
  assign tx_word = tx_q;
  assign tx_pending = pend_q;
  assign rx_dma_req = rxreq_q;
  assign tx_dma_req = txreq_q;
  assign master_mode = mode_q[SDR_MODE_MASTER_BIT];
  assign variable_select_mode = mode_q[SDR_MODE_VARSEL_BIT];
  assign select_decode_mode = mode_q[SDR_MODE_DECODE_BIT];
  assign spi_enabled = enabled_q;
  assign irq = irq_q;

endmodule : sdr_regs

// ===== sdr_monitor.sv
`timescale 1ns/1ps
module sdr_monitor
  import sdr_pkg::*;
(
  input logic clk, // block clock
  input logic rstn, // reset, active low
  input logic wb_cyc_i, // cycle
  input logic wb_stb_i, // strobe
  input logic wb_we_i, // write
  input logic [7:0] wb_adr_i, // address
  input logic [31:0] wb_dat_o, // read data
  input logic wb_ack_o, // acknowledge
  input logic ser_tx_take, // serializer takes word
  input logic tx_pending, // word waiting
  input logic [3:0] chip_select_lines, // selects, active low
  input logic select_decode_mode, // decode mode
  input logic rx_dma_end, // rx channel end
  input logic tx_dma_end, // tx channel end
  input logic rx_dma_req, // rx request
  input logic tx_dma_req, // tx request
  input logic spi_enabled // enabled
);
  // ----------------------------------------------------------------
  // clocking and sequences
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence ans_s; wb_ack_o ##1 !wb_ack_o; endsequence

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  bus_answer_a: assert property (req_s |=> ans_s) else $error("ack not a single pulse after one wait");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h20 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  rx_upper_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == SDR_OFS_RX |-> wb_dat_o[31:20] == 12'h0)
    else $error("rx upper bits set");
  status_free_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == SDR_OFS_STATUS
    |-> wb_dat_o[31:17] == 15'h0 && wb_dat_o[15:6] == 10'h0) else $error("status free bits set");
  enabled_bit_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == SDR_OFS_STATUS
    |-> wb_dat_o[SDR_ENABLED_BIT] == $past(spi_enabled)) else $error("enabled bit wrong");
  rx_req_end_a: assert property (rx_dma_end |=> !rx_dma_req) else $error("rx request at end");
  tx_req_end_a: assert property (tx_dma_end |=> !tx_dma_req) else $error("tx request at end");
  one_select_a: assert property (ser_tx_take && tx_pending && !select_decode_mode
    |=> $countones(~chip_select_lines) <= 1) else $error("more than one select low");
  pend_drop_a: assert property (ser_tx_take && tx_pending |-> ##[1:2] !tx_pending)
    else $error("pending stays after take");
  idle_pend_a: assert property (!spi_enabled |=> !tx_pending) else $error("pending while off");
endmodule : sdr_monitor

bind sdr_regs sdr_monitor i_sdr_monitor (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ser_tx_take(ser_tx_take),
  .tx_pending(tx_pending), .chip_select_lines(chip_select_lines), .select_decode_mode(select_decode_mode),
  .rx_dma_end(rx_dma_end), .tx_dma_end(tx_dma_end), .rx_dma_req(rx_dma_req), .tx_dma_req(tx_dma_req),
  .spi_enabled(spi_enabled));

// ===== sdr_ser_model.sv
`timescale 1ns/1ps
module sdr_ser_model
  import sdr_pkg::*;
#(
  parameter logic [3:0] TAKE_DLY = 4'h8 // cycles a word waits before it is taken
)
(
  input logic clk, // block clock
  input logic tx_pending, // word waiting
  output logic ser_tx_take, // take pulse
  output logic ser_rx_load, // load pulse
  output logic [15:0] ser_rx_word // delivered word
);
  logic [3:0] wait_q; // cycles the pending word has waited
  initial
  begin
    ser_tx_take = 1'b0;
    ser_rx_load = 1'b0;
    ser_rx_word = 16'h0;
    wait_q = 4'h0;
  end
  // take only after a wait, so a short pending tail is not taken twice
  always @(posedge clk)
  begin
    ser_tx_take <= tx_pending && wait_q == TAKE_DLY;
    wait_q <= (tx_pending && wait_q != TAKE_DLY) ? wait_q + 4'h1 : 4'h0;
  end
  // one word for one cycle; the bus then shows its inverse, not a stale copy
  task deliver(input logic [15:0] w);
    @(posedge clk);
    ser_rx_load <= 1'b1;
    ser_rx_word <= w;
    @(posedge clk);
    ser_rx_load <= 1'b0;
    ser_rx_word <= ~w;
  endtask : deliver
endmodule : sdr_ser_model

// ===== test_sdr_regs.sv
`timescale 1ns/1ps
`define CHK(n,e,g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_sdr_regs;
  import sdr_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk, rstn, cyc, stb, we, ack, take, load, pend, fault_n, rx_end, tx_end;
  logic rx_req, tx_req, master, varsel, decsel, enabled, irq;
  logic [7:0] adr; // bus address
  logic [31:0] wdat, rdat; // bus data
  logic [15:0] rword; // received word
  logic [3:0] csl; // select lines
  logic [3:0] sel; // bus byte enables
  sdr_txword_t txw; // pending word
  int error_cnt, checks_done, cyc_cnt, i;
  logic [31:0] mtab [7] = '{32'h3, 32'h3, 32'h3, 32'h3, 32'h7, 32'h2, 32'h000b_0001}; // mode per step
  logic [3:0] stab [7] = '{4'ha, 4'h5, 4'hb, 4'h7, 4'h9, 4'he, 4'h0}; // select written with word
  logic [3:0] ctab [7] = '{4'he, 4'hd, 4'hb, 4'h7, 4'h9, 4'hf, 4'hb}; // lines expected

  sdr_regs i_sdr_regs (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ser_rx_load(load), .ser_rx_word(rword),
    .ser_tx_take(take), .tx_word(txw), .tx_pending(pend), .chip_select_lines(csl), .fault_in_n(fault_n),
    .rx_dma_end(rx_end), .tx_dma_end(tx_end), .rx_dma_req(rx_req), .tx_dma_req(tx_req), .master_mode(master),
    .variable_select_mode(varsel), .select_decode_mode(decsel), .spi_enabled(enabled), .irq(irq));
  sdr_ser_model i_sdr_ser_model (.clk(clk), .tx_pending(pend), .ser_tx_take(take), .ser_rx_load(load),
    .ser_rx_word(rword));

  always #5 clk = ~clk;
  // a hang ends the run as a failure
  always @(posedge clk)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000)
    begin
      error_cnt++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task conclude();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // one classic cycle; the request holds until ack is seen at an edge
  // only the run timeout ends a wait; the slave answers after one wait cycle
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, sel, adr, wdat} <= {2'b11, w, 4'hf, a, d};
    do
    begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    q = rdat;
    {cyc, stb, we} <= 3'b000;
    `CHK("ack wait", 2, n)
  endtask : acc
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask : wr
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    `CHK(nm, e, q & m)
  endtask : rdc
  task wait_take();
    int n;
    n = 0;
    while (take !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
  endtask : wait_take

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    {clk, rstn, cyc, stb, we, sel, adr, wdat, rx_end, tx_end, error_cnt, checks_done, cyc_cnt} = '0;
    fault_n = 1'b1;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rdc("rx", SDR_OFS_RX, 32'hffff_ffff, 32'h0);
    rdc("sr", SDR_OFS_STATUS, 32'hffff_ffff, 32'h0);
    rdc("imr", SDR_OFS_IMR, 32'hffff_ffff, 32'h0);
    rdc("gap", 8'h20, 32'hffff_ffff, 32'h0);
    wr(SDR_OFS_CTRL, 32'h1);
    rdc("sr", SDR_OFS_STATUS, 32'hffff_ffff, 32'h0001_0002);
    `CHK("en", 1'b1, enabled)
    for (i = 0; i < 7; i++)
    begin
      wr(SDR_OFS_MODE, mtab[i]);
      wr(SDR_OFS_TX, {12'h0, stab[i], 16'h00a5});
      if (i == 0) rdc("sr", SDR_OFS_STATUS, 32'h2, 32'h0);
      wait_take();
      `CHK("cs", ctab[i], csl)
      `CHK("txw", {stab[i], 16'h00a5}, {txw.sel, txw.word})
      `CHK("mode", mtab[i][2:0], {decsel, varsel, master})
    end
    rdc("sr", SDR_OFS_STATUS, 32'h2, 32'h2);
    i_sdr_ser_model.deliver(16'h1234);
    rdc("sr", SDR_OFS_STATUS, 32'h9, 32'h1);
    rdc("rx", SDR_OFS_RX, 32'hffff_ffff, 32'h000b_1234);
    rdc("sr", SDR_OFS_STATUS, 32'h1, 32'h0);
    i_sdr_ser_model.deliver(16'h0001);
    i_sdr_ser_model.deliver(16'h0002);
    rdc("sr", SDR_OFS_STATUS, 32'h9, 32'h9);
    rdc("sr", SDR_OFS_STATUS, 32'h8, 32'h0);
    wr(SDR_OFS_MODE, 32'h0);
    i_sdr_ser_model.deliver(16'h00c3);
    rdc("rx", SDR_OFS_RX, 32'hffff_ffff, 32'h0000_00c3);
    wr(SDR_OFS_MODE, 32'h1);
    fault_n <= 1'b0;
    repeat (8) @(posedge clk);
    fault_n <= 1'b1;
    rdc("sr", SDR_OFS_STATUS, 32'h4, 32'h4);
    rdc("sr", SDR_OFS_STATUS, 32'h4, 32'h0);
    wr(SDR_OFS_IER, 32'h2);
    rdc("imr", SDR_OFS_IMR, 32'hffff_ffff, 32'h2);
    `CHK("irq", 1'b1, irq)
    wr(SDR_OFS_IER, 32'h0);
    wr(SDR_OFS_IDR, 32'h0);
    rdc("imr", SDR_OFS_IMR, 32'hffff_ffff, 32'h2);
    wr(SDR_OFS_IDR, 32'h2);
    rdc("imr", SDR_OFS_IMR, 32'hffff_ffff, 32'h0);
    `CHK("irq", 1'b0, irq)
    {rx_end, tx_end} <= 2'b11;
    rdc("sr", SDR_OFS_STATUS, 32'h30, 32'h30);
    `CHK("dreq", 2'b00, {rx_req, tx_req})
    {rx_end, tx_end} <= 2'b00;
    rdc("sr", SDR_OFS_STATUS, 32'h30, 32'h0);
    `CHK("treq", 1'b1, tx_req)
    wr(SDR_OFS_CTRL, 32'h3);
    rdc("sr", SDR_OFS_STATUS, 32'h0001_0002, 32'h0);
    `CHK("en", 1'b0, enabled)
    conclude();
  end
endmodule : test_sdr_regs
